/* verif/rstsc_init_model.sv */
/*
 * Far-side model of the fuse loader and the memory CRC scanner.
 * Assumes handshake levels from the reset controller on i_clk.
 */
`timescale 1ns/1ps
module rstsc_init_model #(
    parameter int FUSE_WAIT = 3,
    parameter int CRC_WAIT  = 5
) (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst,
    // Handshakes
    input  wire logic i_fuse_reload,
    input  wire logic i_crc_scan_start,
    output logic      o_fuse_loaded,
    output logic      o_crc_scan_done
);
    int fuse_cnt;
    int crc_cnt;

    // Each count restarts once the request drops, so no stale done is shown
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            fuse_cnt <= 0;
            crc_cnt  <= 0;
        end
        else
        begin
            fuse_cnt <= i_fuse_reload ? fuse_cnt + 1 : 0;
            crc_cnt  <= i_crc_scan_start ? crc_cnt + 1 : 0;
        end
    end

    assign o_fuse_loaded   = i_fuse_reload && (fuse_cnt >= FUSE_WAIT);
    assign o_crc_scan_done = i_crc_scan_start && (crc_cnt >= CRC_WAIT);
endmodule : rstsc_init_model

/* verif/rstsc_tb_top.sv */
/*
 * Self-checking bench for the reset source controller.
 * Assumes the init model on the fuse and CRC handshakes.
 */
`timescale 1ns/1ps
module rstsc_tb_top;
    logic        i_clk       = 1'b0;
    logic        i_rst       = 1'b1;
    logic [3:0]  addr        = 4'h0;
    logic        rd          = 1'b0;
    logic        wr          = 1'b0;
    logic [31:0] wdata       = 32'h0;
    logic        por         = 1'b1;
    logic [3:0]  src         = 4'h0;
    logic        pin_cfg     = 1'b1;
    logic        bod_en      = 1'b1;
    logic        crc_seen    = 1'b0;
    logic [31:0] rdata;
    logic        wait_req;
    logic        fuse_rl;
    logic        fuse_ok;
    logic        crc_go;
    logic        crc_ok;
    logic        sys_rst;
    logic        dbg_rst;
    int          n_errors    = 0;
    int          checks_done = 0;
    int          cycles      = 0;
    int          boot_len    = 0;
    int          bod_len     = 0;

    always #2.5 i_clk = ~i_clk;

    rstsc_top #(.STARTUP_STEP_CYCLES(2)) rstsc_top_inst (
        .i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1),
        .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wdata), .i_avs_byteenable(4'hf),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req),
        .i_power_on_active(por), .i_brownout_active(src[0]), .i_brownout_enable(bod_en),
        .i_reset_pin_n(~src[1]), .i_reset_pin_config(pin_cfg),
        .i_watchdog_timer_reset(src[2]), .i_debug_program_port_reset(src[3]),
        .i_startup_time_setting(3'h1), .i_startup_crc_scan_select(1'b1),
        .o_fuse_reload(fuse_rl), .i_fuse_loaded(fuse_ok),
        .o_crc_scan_start(crc_go), .i_crc_scan_done(crc_ok),
        .o_sys_rst(sys_rst), .o_debug_rst(dbg_rst)
    );

    rstsc_init_model rstsc_init_model_inst (
        .i_clk(i_clk), .i_rst(i_rst), .i_fuse_reload(fuse_rl),
        .i_crc_scan_start(crc_go), .o_fuse_loaded(fuse_ok), .o_crc_scan_done(crc_ok)
    );

    task automatic print_verdict;
        if (n_errors == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict

    // Whole run needs a few hundred cycles; the ceiling leaves ample margin
    always @(posedge i_clk)
    begin
        cycles++;
        if (crc_go)
            crc_seen <= 1'b1;
        if (cycles == 20000)
        begin
            n_errors++;
            print_verdict();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge i_clk);
        rd    <= ~w;
        wr    <= w;
        addr  <= a;
        wdata <= d;
        do @(posedge i_clk); while (wait_req !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask : rd_chk

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr_reg

    task automatic bit_chk(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : bit_chk

    // Waits out the release sequence; the CRC scan must have been run
    task automatic boot;
        int n;
        n = 0;
        while (sys_rst !== 1'b0 && n < 3000)
        begin
            @(posedge i_clk);
            n++;
        end
        boot_len = n;
        bit_chk(sys_rst, 1'b0);
        bit_chk(crc_seen, 1'b1);
        crc_seen <= 1'b0;
    endtask : boot

    task automatic src_case(input int k, input logic [5:0] f, input logic d);
        @(posedge i_clk);
        src <= 4'h1 << k;
        repeat (4) @(posedge i_clk);
        bit_chk(sys_rst, 1'b1);
        bit_chk(dbg_rst, d);
        src <= 4'h0;
        boot();
        rd_chk(4'h0, {26'h0, f});
        wr_reg(4'h0, 32'h3f);
        rd_chk(4'h0, 32'h0);
    endtask : src_case

    initial
    begin
        repeat (16) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        por <= 1'b0;
        boot();
        rd_chk(4'h0, 32'h1);
        rd_chk(4'h4, 32'h0);
        wr_reg(4'h1, 32'hff);
        wr_reg(4'h0, 32'h0);
        rd_chk(4'h0, 32'h1);
        wr_reg(4'h0, 32'h1);
        rd_chk(4'h0, 32'h0);
        // Trigger without key, then with a wrong key: both ignored
        wr_reg(4'h4, 32'h1);
        wr_reg(4'h8, 32'h0);
        wr_reg(4'h4, 32'h1);
        repeat (3) @(posedge i_clk);
        bit_chk(sys_rst, 1'b0);
        wr_reg(4'h8, {24'h0, rstsc_pkg::UNLOCK_KEY_DEFAULT});
        rd_chk(4'h8, 32'h1);
        wr_reg(4'h4, 32'h1);
        repeat (2) @(posedge i_clk);
        bit_chk(sys_rst, 1'b1);
        bit_chk(dbg_rst, 1'b0);
        boot();
        rd_chk(4'h0, 32'h10);
        rd_chk(4'h4, 32'h0);
        // Power loss must assert reset in the same cycle and wipe other flags
        @(posedge i_clk);
        por <= 1'b1;
        #1;
        bit_chk(sys_rst, 1'b1);
        repeat (3) @(posedge i_clk);
        bit_chk(dbg_rst, 1'b1);
        por <= 1'b0;
        boot();
        rd_chk(4'h0, 32'h1);
        wr_reg(4'h0, 32'h1);
        src_case(0, 6'h02, 1'b1);
        bod_len = boot_len;
        src_case(1, 6'h04, 1'b0);
        // Supply resets add the start-up time: step of 2 shifted by setting 1
        chk(32'(bod_len - boot_len), 32'h4);
        src_case(2, 6'h08, 1'b0);
        src_case(3, 6'h20, 1'b0);
        // Pin, brown-out and watchdog active while disabled must not reset
        wr_reg(4'hc, 32'h0);
        rd_chk(4'hc, 32'h60);
        @(posedge i_clk);
        pin_cfg <= 1'b0;
        bod_en  <= 1'b0;
        src     <= 4'h7;
        repeat (5) @(posedge i_clk);
        bit_chk(sys_rst, 1'b0);
        src     <= 4'h0;
        pin_cfg <= 1'b1;
        bod_en  <= 1'b1;
        rd_chk(4'h0, 32'h0);
        print_verdict();
    end
endmodule : rstsc_tb_top

/* verilog/rstsc_pkg.sv */
/*
 * Constants for the reset source controller: register indices, field
 * positions, reset values, sequencer states and timing figures.
 * Assumes a 200 MHz system clock and a 32-bit Avalon-MM register bus.
 */
package rstsc_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [1:0] IDX_CAUSE_FLAGS = 2'h0;
    localparam logic [1:0] IDX_SW_TRIGGER  = 2'h1;
    localparam logic [1:0] IDX_UNLOCK      = 2'h2;
    localparam logic [1:0] IDX_CONTROL     = 2'h3;
    localparam int         ADDR_W          = 4;

    // ------------------------------------------------------------
    // Cause flag bit positions
    // ------------------------------------------------------------
    localparam int FLAG_POWER_ON = 0;
    localparam int FLAG_BROWNOUT = 1;
    localparam int FLAG_PIN      = 2;
    localparam int FLAG_WATCHDOG = 3;
    localparam int FLAG_SOFTWARE = 4;
    localparam int FLAG_DEBUG    = 5;
    localparam int FLAG_W        = 6;

    localparam logic [5:0] FLAGS_AFTER_POR = 6'h01;

    // Software trigger and control fields
    localparam int SW_REQUEST_BIT   = 0;
    localparam int CTRL_WDT_EN_BIT  = 0;
    localparam logic CTRL_WDT_EN_RST = 1'b1;

    // ------------------------------------------------------------
    // Write protection
    // ------------------------------------------------------------
    localparam logic [7:0] UNLOCK_KEY_DEFAULT = 8'h5a;
    localparam logic [2:0] UNLOCK_ACCESSES    = 3'h4;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS      = 5000;
    localparam int STARTUP_STEP_NS    = 1000;
    localparam int STARTUP_STEP_CYC   = (STARTUP_STEP_NS * 1000) / CLK_PERIOD_PS;
    localparam int STARTUP_CNT_W      = 24;

    // ------------------------------------------------------------
    // Sequencer states, Gray coded along the boot path through ST_STARTUP
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_HOLD    = 3'b000,
        ST_FUSE    = 3'b001,
        ST_STARTUP = 3'b011,
        ST_CRC     = 3'b010,
        ST_RUN     = 3'b110
    } rstsc_state_e;

endpackage : rstsc_pkg

/* verilog/rstsc_top.sv */
/*
 * Reset source controller: gathers power-on, brown-out, pin, watchdog,
 * software and debug-port reset requests, sequences the release of the
 * device reset and records the cause for software.
 * Assumes detector and fuse inputs synchronous to i_clk, and an Avalon-MM
 * master that holds each request until waitrequest is low.
 */
`timescale 1ns/1ps

// Summary of operation
// - Cause of each reset is stored in the cause flag register for software.
// - Pin, brown-out and watchdog sources honoured only when their enable is set.
// - Power-on detector holds reset until start-up and initialization finish.
// - Power-on detector falling below level re-asserts reset at once.
// - Brown-out detector below fuse-selected level issues a reset.
// - Enabled reset pin held low requests reset; release only once high.
// - Watchdog timeout request issues a watchdog reset.
// - Writing one to bit 0 of the software trigger registers a request that starts reset the next cycle.
// - Software reset request bit always reads zero.
// - Trigger write without preceding unlock leaves everything unchanged.
// - All resets reload fuses; only power-on and brown-out reset debug logic.
// - Every reset reloads fuse and signature loaded registers.
// - Start-up delay added after release only for power-supply resets.
// - Initialization extended by the memory CRC scan when selected.
// - Writing one clears a flag; writing zero leaves it.
// - Power-on sets only its flag; others blocked until a full boot.
// - Flags: debug bit 5, software 4, watchdog 3, pin 2, brown-out 1, power-on 0.
// - Debug reset only from the debug port, never from software.
// - Controller has no sleep input; it advances on every clock with i_ce high and holds while i_ce is low.
module rstsc_top #(
    parameter logic [7:0] UNLOCK_KEY          = rstsc_pkg::UNLOCK_KEY_DEFAULT,
    parameter int         STARTUP_STEP_CYCLES = rstsc_pkg::STARTUP_STEP_CYC
) (
    // Clock, reset, enable
    input  wire logic                          i_clk,
    input  wire logic                          i_rst,
    input  wire logic                          i_ce,
    // Avalon-MM slave
    input  wire logic [rstsc_pkg::ADDR_W-1:0]  i_avs_address,
    input  wire logic                          i_avs_read,
    input  wire logic                          i_avs_write,
    input  wire logic [31:0]                   i_avs_writedata,
    input  wire logic [3:0]                    i_avs_byteenable,
    output logic [31:0]                        o_avs_readdata,
    output logic                               o_avs_waitrequest,
    // Reset sources
    input  wire logic                          i_power_on_active,
    input  wire logic                          i_brownout_active,
    input  wire logic                          i_brownout_enable,
    input  wire logic                          i_reset_pin_n,
    input  wire logic                          i_reset_pin_config,
    input  wire logic                          i_watchdog_timer_reset,
    input  wire logic                          i_debug_program_port_reset,
    // Fuse settings
    input  wire logic [2:0]                    i_startup_time_setting,
    input  wire logic                          i_startup_crc_scan_select,
    // Initialization handshakes
    output logic                               o_fuse_reload,
    input  wire logic                          i_fuse_loaded,
    output logic                               o_crc_scan_start,
    input  wire logic                          i_crc_scan_done,
    // Reset outputs
    output logic                               o_sys_rst,
    output logic                               o_debug_rst
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        rstsc_pkg::rstsc_state_e           st;
        logic [rstsc_pkg::FLAG_W-1:0]      flags;
        logic                              power_cause;
        logic                              boot_seen;
        logic                              sw_req;
        logic                              wdt_en;
        logic [2:0]                        unlock_cnt;
        logic [rstsc_pkg::STARTUP_CNT_W-1:0] cnt;
        logic                              ack;
        logic [7:0]                        rdata;
    } rstsc_s;

    rstsc_s s;
    rstsc_s next_s;

    logic                              bus_req;
    logic                              bus_take;
    logic [1:0]                        widx;
    logic                              wmapped;
    logic                              src_level;
    logic                              src_any;
    logic                              power_src;
    logic [rstsc_pkg::FLAG_W-1:0]      set_flags;
    logic [rstsc_pkg::FLAG_W-1:0]      clr_flags;
    logic [rstsc_pkg::STARTUP_CNT_W-1:0] startup_target;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // One wait cycle per access keeps read data registered.
    assign bus_req  = i_avs_read | i_avs_write;
    assign bus_take = bus_req & s.ack;
    assign widx     = i_avs_address[3:2];
    assign wmapped  = (i_avs_address[1:0] == 2'h0);
    assign o_avs_waitrequest = bus_req & ~s.ack;
    assign o_avs_readdata    = {24'h000000, s.rdata};

    // ------------------------------------------------------------
    // Source gathering
    // ------------------------------------------------------------
    assign power_src = i_power_on_active
                     | (i_brownout_enable & i_brownout_active);
    // Debug requests enter only through the port input, never a register.
    assign src_level = power_src
                     | (i_reset_pin_config & ~i_reset_pin_n)
                     | (s.wdt_en & i_watchdog_timer_reset)
                     | i_debug_program_port_reset;
    assign src_any   = src_level | s.sw_req;

    always_comb
    begin
        set_flags = '0;
        set_flags[rstsc_pkg::FLAG_BROWNOUT] = i_brownout_enable & i_brownout_active;
        set_flags[rstsc_pkg::FLAG_PIN]      = i_reset_pin_config & ~i_reset_pin_n;
        set_flags[rstsc_pkg::FLAG_WATCHDOG] = s.wdt_en & i_watchdog_timer_reset;
        set_flags[rstsc_pkg::FLAG_SOFTWARE] = s.sw_req;
        set_flags[rstsc_pkg::FLAG_DEBUG]    = i_debug_program_port_reset;
        if (!s.boot_seen)
        begin
            set_flags = '0;
        end
    end

    assign clr_flags = (bus_take && i_avs_write && wmapped && i_avs_byteenable[0]
                        && widx == rstsc_pkg::IDX_CAUSE_FLAGS)
                     ? i_avs_writedata[rstsc_pkg::FLAG_W-1:0] : '0;

    assign startup_target = rstsc_pkg::STARTUP_CNT_W'(STARTUP_STEP_CYCLES)
                            << i_startup_time_setting;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_s     = s;
        next_s.ack = bus_req & ~s.ack;

        // Cause flags: a set in the clearing cycle wins.
        next_s.flags = (s.flags & ~clr_flags) | set_flags;
        if (i_power_on_active)
        begin
            next_s.flags     = rstsc_pkg::FLAGS_AFTER_POR;
            next_s.boot_seen = 1'b0;
        end

        // Read data, captured in the cycle before the answer
        next_s.rdata = 8'h00;
        if (i_avs_read && !s.ack && wmapped)
        begin
            unique case (widx)
                rstsc_pkg::IDX_CAUSE_FLAGS: next_s.rdata = {2'b00, s.flags};
                rstsc_pkg::IDX_SW_TRIGGER:  next_s.rdata = 8'h00;
                rstsc_pkg::IDX_UNLOCK:      next_s.rdata = {7'h00, s.unlock_cnt != 3'h0};
                rstsc_pkg::IDX_CONTROL:     next_s.rdata = {1'b0, s.st, 3'h0, s.wdt_en};
            endcase
        end

        // Unlock window counts completed bus accesses after the key.
        if (bus_take && s.unlock_cnt != 3'h0)
        begin
            next_s.unlock_cnt = s.unlock_cnt - 3'h1;
        end
        if (bus_take && i_avs_write && wmapped && i_avs_byteenable[0])
        begin
            unique case (widx)
                rstsc_pkg::IDX_UNLOCK:
                begin
                    next_s.unlock_cnt = (i_avs_writedata[7:0] == UNLOCK_KEY)
                                      ? rstsc_pkg::UNLOCK_ACCESSES : 3'h0;
                end
                rstsc_pkg::IDX_SW_TRIGGER:
                begin
                    // A locked write is dropped without effect.
                    if (s.unlock_cnt != 3'h0 &&
                        i_avs_writedata[rstsc_pkg::SW_REQUEST_BIT])
                    begin
                        next_s.sw_req = 1'b1;
                    end
                    next_s.unlock_cnt = 3'h0;
                end
                rstsc_pkg::IDX_CONTROL:
                begin
                    next_s.wdt_en = i_avs_writedata[rstsc_pkg::CTRL_WDT_EN_BIT];
                end
                default:
                begin
                end
            endcase
        end

        // Sequencer
        if (src_any)
        begin
            // Any active source, in any state, restarts the hold on the next enabled clock.
            next_s.st     = rstsc_pkg::ST_HOLD;
            next_s.sw_req = 1'b0;
            next_s.cnt    = '0;
            if (s.st == rstsc_pkg::ST_RUN)
            begin
                next_s.power_cause = power_src;
            end
            else
            begin
                next_s.power_cause = s.power_cause | power_src;
            end
        end
        else
        begin
            unique case (s.st)
                rstsc_pkg::ST_HOLD:
                begin
                    next_s.st = rstsc_pkg::ST_FUSE;
                end
                rstsc_pkg::ST_FUSE:
                begin
                    if (i_fuse_loaded)
                    begin
                        next_s.st = s.power_cause ? rstsc_pkg::ST_STARTUP
                                                  : rstsc_pkg::ST_CRC;
                    end
                end
                rstsc_pkg::ST_STARTUP:
                begin
                    next_s.cnt = s.cnt + 1'b1;
                    if (s.cnt + 1'b1 >= startup_target)
                    begin
                        next_s.st  = rstsc_pkg::ST_CRC;
                        next_s.cnt = '0;
                    end
                end
                rstsc_pkg::ST_CRC:
                begin
                    if (!i_startup_crc_scan_select || i_crc_scan_done)
                    begin
                        next_s.st        = rstsc_pkg::ST_RUN;
                        next_s.boot_seen = 1'b1;
                    end
                end
                rstsc_pkg::ST_RUN:
                begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // No sleep input exists: the controller advances only on clocks with i_ce high.
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            s             <= '0;
            s.st          <= rstsc_pkg::ST_HOLD;
            s.flags       <= rstsc_pkg::FLAGS_AFTER_POR;
            s.power_cause <= 1'b1;
            s.wdt_en      <= rstsc_pkg::CTRL_WDT_EN_RST;
        end
        else if (i_ce)
        begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_fuse_reload    = (s.st == rstsc_pkg::ST_FUSE);
    assign o_crc_scan_start = (s.st == rstsc_pkg::ST_CRC) & i_startup_crc_scan_select;
    // Power-on bypasses the sequencer so reset rises with no clock delay.
    assign o_sys_rst   = (s.st != rstsc_pkg::ST_RUN) | i_power_on_active;
    assign o_debug_rst = ((s.st != rstsc_pkg::ST_RUN) & s.power_cause)
                       | i_power_on_active;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    AST_POR_IMMEDIATE: assert property (
        i_power_on_active |-> o_sys_rst && o_debug_rst)
        else $error("power-on active without reset");

    AST_PIN_HOLDS: assert property (
        i_reset_pin_config && !i_reset_pin_n && i_ce |=> o_sys_rst)
        else $error("pin low without reset");

    AST_POR_FLAGS: assert property (
        i_power_on_active && i_ce |=> s.flags == rstsc_pkg::FLAGS_AFTER_POR)
        else $error("flags wrong after power-on");

    AST_DEBUG_POWER_ONLY: assert property (
        o_debug_rst && !i_power_on_active |-> s.power_cause && o_sys_rst)
        else $error("debug reset without power cause");

    AST_STARTUP_POWER_ONLY: assert property (
        s.st == rstsc_pkg::ST_STARTUP |-> s.power_cause)
        else $error("start-up delay on non-power reset");

    AST_SW_READS_ZERO: assert property (
        i_avs_read && !o_avs_waitrequest && i_avs_address == 4'h4
        |-> o_avs_readdata == 32'h00000000)
        else $error("software trigger read nonzero");

    AST_SW_TRIGGER: assert property (
        i_ce && i_avs_write && !o_avs_waitrequest && i_avs_address == 4'h4
        && i_avs_byteenable[0] && i_avs_writedata[0] && s.unlock_cnt != 3'h0
        |=> s.sw_req ##1 (s.st == rstsc_pkg::ST_HOLD || !i_ce))
        else $error("unlocked trigger did not reset");

    AST_LOCKED_IGNORED: assert property (
        i_ce && i_avs_write && !o_avs_waitrequest && i_avs_address == 4'h4
        && s.unlock_cnt == 3'h0 && !s.sw_req |=> !s.sw_req)
        else $error("locked trigger write took effect");

    AST_FLAG_CLEAR: assert property (
        i_ce && i_avs_write && !o_avs_waitrequest && i_avs_address == 4'h0
        && i_avs_byteenable[0] && !src_level && !s.sw_req
        |=> (s.flags & $past(i_avs_writedata[5:0])) == 6'h00)
        else $error("flag not cleared by write of one");

    AST_WAIT_ONE: assert property (
        bus_req && !s.ack && i_ce |=> !o_avs_waitrequest || !bus_req)
        else $error("waitrequest held more than one cycle");

endmodule : rstsc_top
